/* File: sesf_pkg.sv */
// Package with register map, field layout and timing constants of the supply event flags.
package sesf_pkg;
  // Register word offsets (byte addresses).
  localparam logic [7:0] SESF_STATUS_OFS = 8'h24;
  localparam logic [7:0] SESF_MASK_OFS = 8'h28;
  localparam logic [7:0] SESF_SLOWDIV_OFS = 8'h2C;
  // Status field positions.
  localparam int SESF_FORCE_WAKE_BIT = 0;
  localparam int SESF_PIN_WAKE_BIT = 1;
  localparam int SESF_MON_WAKE_BIT = 2;
  localparam int SESF_BROWNOUT_BIT = 3;
  localparam int SESF_MON_RESET_BIT = 4;
  localparam int SESF_MON_DETECT_BIT = 5;
  localparam int SESF_NFLAGS = 6;
  // Reset values.
  localparam logic [5:0] SESF_FLAGS_RST = 6'h00;
  localparam logic [5:0] SESF_MASK_RST = 6'h00;
  // Slow clock enable derived from the 10 MHz system clock.
  localparam int SESF_CLK_HZ = 10000000;
  localparam int SESF_SLOW_HZ = 32768;
  localparam int SESF_SLOW_DIV = SESF_CLK_HZ / SESF_SLOW_HZ;
  localparam logic [15:0] SESF_SLOWDIV_RST = 16'(SESF_SLOW_DIV - 1);
  // Slow-clock ticks between a status read and the clear taking effect.
  localparam logic [1:0] SESF_CLEAR_TICKS = 2'h2;
endpackage : sesf_pkg

/* File: sesf_tick_div.sv */
// Divider producing the slow clock enable, one cycle wide when div_max is nonzero.
`timescale 1ns/1ps
`default_nettype none
module sesf_tick_div (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Divide control and enable output.
  input wire logic [15:0] div_max,
  output logic tick
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_q >= div_max) begin
      cnt_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : sesf_tick_div
`default_nettype wire

/* File: sesf_supply_flags.sv */
// Sticky supply event status flags with read-clear, mask and interrupt.
//
// Summary of operation
// - Force-wake wake-up sets its flag; held until status read clears it.
// - Wake-up pin wake-up sets its flag; held until status read clears it.
// - Monitor-caused wake-up sets its flag; held until status read clears it.
// - Brownout output rising edge sets its flag; status read clears it.
// - Brownout output held high does not set the flag again.
// - Monitor-caused core reset sets its flag; status read clears it.
// - Any monitor detection sets its flag; status read clears it.
// - A read clear takes effect two slow-clock ticks after the read.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sesf_supply_flags
  import sesf_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Event inputs, one-cycle pulses except the brownout level.
  input wire logic force_wake_input,
  input wire logic wake_input_pins,
  input wire logic monitor_wake_evt,
  input wire logic brownout_out,
  input wire logic monitor_reset_evt,
  input wire logic monitor_detect_evt,
  // Interrupt.
  output logic irq
);
  logic [5:0] flags_q;
  logic [5:0] flags_d;
  logic [5:0] mask_q;
  logic [15:0] div_q;
  logic [5:0] evt_hold_q;
  logic [5:0] rd_snap_q;
  logic [5:0] evt_now;
  logic brown_q;
  logic brown_rise;
  logic clr_pend_q;
  logic [1:0] clr_cnt_q;
  logic clr_apply;
  logic slow_tick;
  logic [31:0] rdata_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : hit

  sesf_tick_div u_div (
    .clk(clk),
    .arst_n(arst_n),
    .div_max(div_q),
    .tick(slow_tick)
  );

  // Brownout edge detect; a steady high level gives no new event.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      brown_q <= 1'b0;
    end else begin
      brown_q <= brownout_out;
    end
  end
  assign brown_rise = brownout_out && !brown_q;

  always_comb begin
    evt_now = 6'h00;
    evt_now[SESF_FORCE_WAKE_BIT] = force_wake_input;
    evt_now[SESF_PIN_WAKE_BIT] = wake_input_pins;
    evt_now[SESF_MON_WAKE_BIT] = monitor_wake_evt;
    evt_now[SESF_BROWNOUT_BIT] = brown_rise;
    evt_now[SESF_MON_RESET_BIT] = monitor_reset_evt;
    evt_now[SESF_MON_DETECT_BIT] = monitor_detect_evt;
  end

  // Events are held until the next slow tick, since the flags live in the
  // slow domain and a system-clock pulse would otherwise be missed.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_hold_q <= SESF_FLAGS_RST;
    end else if (slow_tick) begin
      // The tick itself folds evt_now into the flags, so the hold empties;
      // keeping it would replay an old event onto a flag just cleared.
      evt_hold_q <= SESF_FLAGS_RST;
    end else begin
      evt_hold_q <= evt_hold_q | evt_now;
    end
  end

  // Clear scheduling: counts two slow ticks after a status read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
    end else if (reg_rd && hit(reg_addr, SESF_STATUS_OFS)) begin
      clr_pend_q <= 1'b1;
      clr_cnt_q <= 2'h0;
    end else if (clr_apply) begin
      clr_pend_q <= 1'b0;
      clr_cnt_q <= 2'h0;
    end else if (clr_pend_q && slow_tick) begin
      clr_cnt_q <= clr_cnt_q + 2'h1;
    end
  end
  assign clr_apply = clr_pend_q && slow_tick &&
                     (clr_cnt_q == SESF_CLEAR_TICKS - 2'h1);

  // Only the flags that a status read returned are removed by its clear, so
  // an event that lands while the clear is pending is kept, except on a flag the read returned before the first tick.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_snap_q <= SESF_FLAGS_RST;
    end else if (reg_rd && hit(reg_addr, SESF_STATUS_OFS)) begin
      rd_snap_q <= flags_q;
    end
  end

  always_comb begin
    flags_d = flags_q;
    if (slow_tick) begin
      if (clr_apply) begin
        flags_d = flags_q & ~rd_snap_q;
      end
      flags_d = flags_d | evt_hold_q | evt_now;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= SESF_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Configuration writes.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= SESF_MASK_RST;
      div_q <= SESF_SLOWDIV_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, SESF_MASK_OFS)) begin
        mask_q <= reg_wdata[5:0];
      end
      if (hit(reg_addr, SESF_SLOWDIV_OFS)) begin
        div_q <= reg_wdata[15:0];
      end
    end
  end

  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      if (hit(reg_addr, SESF_STATUS_OFS)) begin
        rdata_d = {26'h0, flags_q};
      end else if (hit(reg_addr, SESF_MASK_OFS)) begin
        rdata_d = {26'h0, mask_q};
      end else if (hit(reg_addr, SESF_SLOWDIV_OFS)) begin
        rdata_d = {16'h0000, div_q};
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
      irq <= 1'b0;
    end else begin
      reg_rdata <= rdata_d;
      irq <= |(flags_d & mask_q);
    end
  end

  // Flag setting on a slow tick.
  a_brown_steady: assert property (@(posedge clk) disable iff (!arst_n)
    (brownout_out && $past(brownout_out) && !slow_tick && !$past(slow_tick)
     && !clr_apply)
    |=> flags_q[SESF_BROWNOUT_BIT] == $past(flags_q[SESF_BROWNOUT_BIT]))
    else $error("brownout flag moved without an edge");
  a_brown_set: assert property (@(posedge clk) disable iff (!arst_n)
    brown_rise && slow_tick |=> flags_q[SESF_BROWNOUT_BIT])
    else $error("brownout edge not recorded");
  a_force_set: assert property (@(posedge clk) disable iff (!arst_n)
    force_wake_input && slow_tick |=> flags_q[SESF_FORCE_WAKE_BIT])
    else $error("force wake not recorded");
  a_pin_set: assert property (@(posedge clk) disable iff (!arst_n)
    wake_input_pins && slow_tick |=> flags_q[SESF_PIN_WAKE_BIT])
    else $error("pin wake not recorded");
  a_monwake_set: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_wake_evt && slow_tick |=> flags_q[SESF_MON_WAKE_BIT])
    else $error("monitor wake not recorded");
  a_monrst_set: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_reset_evt && slow_tick |=> flags_q[SESF_MON_RESET_BIT])
    else $error("monitor reset not recorded");
  a_mondet_set: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_detect_evt && slow_tick |=> flags_q[SESF_MON_DETECT_BIT])
    else $error("monitor detect not recorded");

  // Events between ticks wait in the hold register.
  a_force_hold: assert property (@(posedge clk) disable iff (!arst_n)
    force_wake_input && !slow_tick |=> evt_hold_q[SESF_FORCE_WAKE_BIT])
    else $error("force wake not held");
  a_pin_hold: assert property (@(posedge clk) disable iff (!arst_n)
    wake_input_pins && !slow_tick |=> evt_hold_q[SESF_PIN_WAKE_BIT])
    else $error("pin wake not held");
  a_monwake_hold: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_wake_evt && !slow_tick |=> evt_hold_q[SESF_MON_WAKE_BIT])
    else $error("monitor wake not held");
  a_brown_hold: assert property (@(posedge clk) disable iff (!arst_n)
    brown_rise && !slow_tick |=> evt_hold_q[SESF_BROWNOUT_BIT])
    else $error("brownout edge not held");
  a_monrst_hold: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_reset_evt && !slow_tick |=> evt_hold_q[SESF_MON_RESET_BIT])
    else $error("monitor reset not held");
  a_mondet_hold: assert property (@(posedge clk) disable iff (!arst_n)
    monitor_detect_evt && !slow_tick |=> evt_hold_q[SESF_MON_DETECT_BIT])
    else $error("monitor detect not held");
  a_hold_flush: assert property (@(posedge clk) disable iff (!arst_n)
    slow_tick |=> evt_hold_q == 6'h00)
    else $error("hold not emptied on tick");
  a_hold_keep: assert property (@(posedge clk) disable iff (!arst_n)
    !slow_tick |=> (evt_hold_q & $past(evt_now)) == $past(evt_now))
    else $error("held event dropped");
  a_brown_track: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> brown_q == $past(brownout_out))
    else $error("brownout history wrong");

  // Flags only change on ticks and only fall through a read clear.
  a_clear_late: assert property (@(posedge clk) disable iff (!arst_n)
    flags_q != 6'h00 && !slow_tick |=> flags_q == $past(flags_q))
    else $error("flags changed off a slow tick");
  a_flags_sticky: assert property (@(posedge clk) disable iff (!arst_n)
    !clr_apply |=> ($past(flags_q) & ~flags_q) == 6'h00)
    else $error("flag fell without a read clear");
  a_status_ro: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr && hit(reg_addr, SESF_STATUS_OFS) && !slow_tick
    |=> flags_q == $past(flags_q))
    else $error("status write changed flags");
  a_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
    clr_apply && (evt_now != 6'h00) |=> (flags_q & $past(evt_now)) != 6'h00)
    else $error("event lost under clear");
  a_clear_done: assert property (@(posedge clk) disable iff (!arst_n)
    clr_apply && evt_now == 6'h00 && evt_hold_q == 6'h00
    |=> (flags_q & $past(rd_snap_q)) == 6'h00)
    else $error("read clear not applied");

  // Clear scheduling after a status read.
  a_pend_start: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_STATUS_OFS) |=> clr_pend_q)
    else $error("status read did not schedule a clear");
  a_pend_end: assert property (@(posedge clk) disable iff (!arst_n)
    clr_apply && !(reg_rd && hit(reg_addr, SESF_STATUS_OFS)) |=> !clr_pend_q)
    else $error("clear still pending after apply");
  a_snap_take: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_STATUS_OFS) |=> rd_snap_q == $past(flags_q))
    else $error("read snapshot wrong");
  a_snap_keep: assert property (@(posedge clk) disable iff (!arst_n)
    !(reg_rd && hit(reg_addr, SESF_STATUS_OFS)) |=> $stable(rd_snap_q))
    else $error("read snapshot moved");
  a_apply_tick: assert property (@(posedge clk) disable iff (!arst_n)
    clr_apply |-> slow_tick)
    else $error("clear applied off a tick");
  a_cnt_range: assert property (@(posedge clk) disable iff (!arst_n)
    clr_cnt_q < SESF_CLEAR_TICKS)
    else $error("clear counter out of range");
  a_idle_cnt: assert property (@(posedge clk) disable iff (!arst_n)
    !clr_pend_q |-> clr_cnt_q == 2'h0)
    else $error("clear counter runs while idle");
  a_cnt_step: assert property (@(posedge clk) disable iff (!arst_n)
    clr_pend_q && slow_tick && !clr_apply &&
    !(reg_rd && hit(reg_addr, SESF_STATUS_OFS))
    |=> clr_cnt_q == $past(clr_cnt_q) + 2'h1)
    else $error("clear counter missed a tick");
  a_tick_gap: assert property (@(posedge clk) disable iff (!arst_n)
    slow_tick && div_q != 16'h0000 |=> !slow_tick)
    else $error("slow tick longer than one cycle");

  // Register port and interrupt.
  a_rdata_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data outside a read");
  a_rdata_status: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_STATUS_OFS)
    |=> reg_rdata == {26'h0, $past(flags_q)})
    else $error("status read data wrong");
  a_rdata_mask: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_MASK_OFS)
    |=> reg_rdata == {26'h0, $past(mask_q)})
    else $error("mask read data wrong");
  a_rdata_div: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_SLOWDIV_OFS)
    |=> reg_rdata == {16'h0000, $past(div_q)})
    else $error("divider read data wrong");
  a_rdata_unmapped: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && !hit(reg_addr, SESF_STATUS_OFS) && !hit(reg_addr, SESF_MASK_OFS)
    && !hit(reg_addr, SESF_SLOWDIV_OFS) |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_mask_write: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr && hit(reg_addr, SESF_MASK_OFS) |=> mask_q == $past(reg_wdata[5:0]))
    else $error("mask write lost");
  a_div_write: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr && hit(reg_addr, SESF_SLOWDIV_OFS)
    |=> div_q == $past(reg_wdata[15:0]))
    else $error("divider write lost");
  a_mask_keep: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_wr |=> $stable(mask_q))
    else $error("mask moved without a write");
  a_div_keep: assert property (@(posedge clk) disable iff (!arst_n)
    !reg_wr |=> $stable(div_q))
    else $error("divider moved without a write");
  a_irq_follow: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> irq == |(flags_q & $past(mask_q)))
    else $error("interrupt does not follow masked flags");
  a_no_flag_irq: assert property (@(posedge clk) disable iff (!arst_n)
    flags_q == 6'h00 |-> !irq)
    else $error("interrupt without a flag");

  c_read_clear: cover property (@(posedge clk) disable iff (!arst_n)
    clr_apply && flags_q != 6'h00);
  c_brown_edge: cover property (@(posedge clk) disable iff (!arst_n)
    brown_rise);
  c_irq_high: cover property (@(posedge clk) disable iff (!arst_n) irq);
  c_reread: cover property (@(posedge clk) disable iff (!arst_n)
    reg_rd && hit(reg_addr, SESF_STATUS_OFS) && clr_pend_q);
  c_set_pending: cover property (@(posedge clk) disable iff (!arst_n)
    clr_pend_q && evt_now != 6'h00);
endmodule : sesf_supply_flags
`default_nettype wire

/* File: sesf_supply_flags_tb.sv */
// Self-checking testbench for the supply event status flags.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module sesf_supply_flags_tb;
  import sesf_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [5:0] ev = 6'h00;
  logic irq;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] lfsr = 32'h93BE8C35;
  logic [31:0] d;
  logic [5:0] pat;
  logic [5:0] msk;

  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  sesf_supply_flags sesf_supply_flags_inst (
    .clk(clk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .force_wake_input(ev[0]), .wake_input_pins(ev[1]),
    .monitor_wake_evt(ev[2]), .brownout_out(ev[3]),
    .monitor_reset_evt(ev[4]), .monitor_detect_evt(ev[5]), .irq(irq)
  );

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // A one-cycle pulse also gives the brownout level a single rising edge.
  task automatic pulse(input logic [5:0] p);
    @(posedge clk);
    ev <= p;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    #5000000;
    fails++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h0)
    rd_reg(SESF_MASK_OFS); `CHK(d[5:0], SESF_MASK_RST)
    rd_reg(SESF_SLOWDIV_OFS); `CHK(d[15:0], SESF_SLOWDIV_RST)
    rd_reg(8'h00); `CHK(d, 32'h0)
    wr_reg(SESF_STATUS_OFS, 32'hFF);
    wr_reg(SESF_SLOWDIV_OFS, 32'h3);
    rd_reg(SESF_SLOWDIV_OFS); `CHK(d, 32'h3)
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h0)
    `CHK(irq, 1'b0)
    $display("test registers done");
    for (int i = 0; i < SESF_NFLAGS; i++) begin
      pulse(6'(1 << i));
      idle(16);
      rd_reg(SESF_STATUS_OFS); `CHK(d, 32'(1 << i))
      rd_reg(SESF_STATUS_OFS); `CHK(d, 32'(1 << i))
      idle(16);
      rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h0)
    end
    $display("test each flag done");
    ev[3] <= 1'b1;
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h8)
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h0)
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h0)
    ev[3] <= 1'b0;
    idle(4);
    ev[3] <= 1'b1;
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h8)
    ev[3] <= 1'b0;
    idle(16);
    $display("test brownout level done");
    pulse(6'h01);
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h1)
    pulse(6'h02);
    idle(16);
    rd_reg(SESF_STATUS_OFS); `CHK(d, 32'h2)
    idle(16);
    $display("test set over clear done");
    for (int k = 0; k < 20; k++) begin
      lfsr = lfsr_next(lfsr);
      pat = lfsr[5:0];
      msk = lfsr[13:8];
      wr_reg(SESF_MASK_OFS, {26'h0, msk});
      rd_reg(SESF_MASK_OFS); `CHK(d, {26'h0, msk})
      pulse(pat);
      idle(16);
      `CHK(irq, |(pat & msk))
      rd_reg(SESF_STATUS_OFS); `CHK(d, {26'h0, pat})
      idle(16);
      `CHK(irq, 1'b0)
    end
    $display("test random events and interrupt done");
    conclude();
  end
endmodule : sesf_supply_flags_tb
`default_nettype wire
